/* File: rtl/ais_pkg.sv */
// Package for the converter instruction sequencer: opcodes, register map,
// reset values, state and operation types.
// Assumes the instruction decoder hands over whole opcodes and operands.
// Functional notes
// - Opcode 07 switches converter supply on; flags stay unchanged.
// - Opcode 17 switches converter supply off; flags stay unchanged.
// - Initialization, halt and power-off switch converter supply off.
// - Opcodes AC-AF measure the input chosen by low opcode bits, count+1 times, twice that in single mode 0.
// - Operand byte: low seven bits repeat count, top bit single mode.
// - Single mode 0: count+1 normal plus count+1 swapped samples accumulated.
// - Single mode 1: only count+1 normal samples accumulated.
// - Each measure and capture sample checked; error sets negative flag, aborts, zero flag tells which.
// - Reading 000 gives 0/1/1, FFF gives 0/0/1, else 1/0/0 for pos/zero/neg.
// - Measure clears reference select, supply on before sampling, off after.
// - Measure total is written into the result accumulator at the end.
// - Opcode E8 sets reference select, captures one reference sample into accumulator.
// - Opcode EA sets reference select, compares reference sample with accumulator.
// - Opcode E9 clears reference select, captures one input sample into accumulator.
// - Opcode EB compares one input sample with accumulator; zero flag stays 0.
package ais_pkg;

  localparam logic [7:0] OP_SUPPLY_ON = 8'h07;
  localparam logic [7:0] OP_SUPPLY_OFF = 8'h17;
  localparam logic [5:0] OP_MEASURE_HI = 6'h2b;
  localparam logic [7:0] OP_REF_CAPTURE = 8'he8;
  localparam logic [7:0] OP_INPUT_CAPTURE = 8'he9;
  localparam logic [7:0] OP_REF_CHECK = 8'hea;
  localparam logic [7:0] OP_INPUT_CHECK = 8'heb;

  localparam int SAMPLE_W = 12;
  localparam logic [11:0] SAMPLE_LOW = 12'h000;
  localparam logic [11:0] SAMPLE_HIGH = 12'hfff;
  localparam int SUM_W = 20;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SAMPLE = 4'h8;
  localparam logic [7:0] CTRL_SETTLE_RESET = 8'h04;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_REQ = 3'b010,
    ST_WAIT = 3'b011
  } ais_state_t;

  typedef enum logic [2:0] {
    K_MEASURE = 3'b000,
    K_REF_CAP = 3'b001,
    K_IN_CAP = 3'b010,
    K_REF_CHK = 3'b011,
    K_IN_CHK = 3'b100
  } ais_kind_t;

endpackage

/* File: rtl/ais_conv_if.sv */
// Carrier between the sequencer core and its comparator front-end port.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ais_conv_if;
  logic req;
  logic swap;
  logic ack;
  logic [11:0] sample;
  modport seq (output req, output swap, input ack, input sample);
  modport port (input req, input swap, output ack, output sample);
endinterface

/* File: rtl/ais_conv_port.sv */
// Handshake with the analog comparator front end: start pulse out,
// synchronised done level in, sample captured on the done rise.
// Assumes the front end holds data stable while done is high.
`timescale 1ns/1ps
module ais_conv_port (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  ais_conv_if.port cv,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  output logic conv_start_o,
  output logic conv_swap_o
);

  logic [2:0] done_sync_q;
  logic done_lvl_q;
  logic start_q;
  logic swap_q;
  logic ack_q;
  logic [11:0] sample_q;
  logic done_rise;

  ////////////////////////////////////////////////////////////////////////
  // Three-stage synchroniser, level accepted once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_sync_q <= 3'h0;
      done_lvl_q <= 1'b0;
    end else begin
      done_sync_q <= {done_sync_q[1:0], conv_done_i};
      if (done_sync_q[1] == done_sync_q[2]) begin
        done_lvl_q <= done_sync_q[2];
      end
    end
  end

  assign done_rise = (done_sync_q[1] == done_sync_q[2]) && done_sync_q[2] && !done_lvl_q;

  // Start pulse and swap level toward the comparator
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_q <= 1'b0;
      swap_q <= 1'b0;
    end else begin
      start_q <= cv.req;
      if (cv.req) begin
        swap_q <= cv.swap;
      end
    end
  end

  // Sample capture; data is parallel so only done needs the synchroniser
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
      sample_q <= 12'h000;
    end else begin
      ack_q <= done_rise;
      if (done_rise) begin
        sample_q <= conv_data_i;
      end
    end
  end

  assign cv.ack = ack_q;
  assign cv.sample = sample_q;
  assign conv_start_o = start_q;
  assign conv_swap_o = swap_q;

  property p_start_pulse;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      cv.req |=> conv_start_o && (conv_swap_o == $past(cv.swap)) ##1 !conv_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a single pulse");

endmodule

/* File: rtl/ais_adc_sequencer.sv */
// Converter instruction sequencer: supply switching, multi-sample measure,
// single captures and compares against the accumulator, plus a small
// register port for the settle delay and status.
// Assumes instructions arrive as one-cycle strobes from the decoder.
`timescale 1ns/1ps
module ais_adc_sequencer (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic [7:0] operand_i,
  input wire logic [31:0] acc_i,
  input wire logic init_i,
  input wire logic halt_i,
  input wire logic power_off_i,
  input wire logic input_select_low_i,
  input wire logic input_select_high_i,
  output logic busy_o,
  output logic done_o,
  output logic pos_flag_o,
  output logic zero_flag_o,
  output logic negative_flag_o,
  output logic acc_wr_o,
  output logic [31:0] acc_data_o,
  output logic converter_supply_o,
  output logic reference_select_line_o,
  output logic [1:0] input_sel_o,
  output logic conv_start_o,
  output logic conv_swap_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);

  ais_conv_if cv ();

  ais_pkg::ais_state_t state_q;
  ais_pkg::ais_kind_t kind_q;
  ais_pkg::ais_kind_t kind_d;
  logic [6:0] rep_q;
  logic [7:0] cnt_q;
  logic single_q;
  logic swap_q;
  logic [ais_pkg::SUM_W-1:0] sum_q;
  logic [ais_pkg::SUM_W-1:0] sum_d;
  logic [7:0] settle_q;
  logic [7:0] ctrl_settle_q;
  logic [11:0] last_sample_q;
  logic supply_q;
  logic ref_sel_q;
  logic [1:0] sel_q;
  logic pos_q;
  logic zero_q;
  logic neg_q;
  logic busy_q;
  logic done_q;
  logic acc_wr_q;
  logic [31:0] acc_data_q;
  logic [31:0] rdata_q;
  logic stop;
  logic start;
  logic is_meas;
  logic is_sample_op;
  logic smp_err;
  logic last_smp;
  logic fin;
  logic is_check;
  logic cmp_gt;

  ////////////////////////////////////////////////////////////////////////
  // Decode
  assign stop = init_i | halt_i | power_off_i;
  assign start = instr_valid_i && (state_q == ais_pkg::ST_IDLE) && !stop;
  assign is_meas = (opcode_i[7:2] == ais_pkg::OP_MEASURE_HI);
  assign is_sample_op = is_meas || (opcode_i == ais_pkg::OP_REF_CAPTURE) ||
                        (opcode_i == ais_pkg::OP_INPUT_CAPTURE) ||
                        (opcode_i == ais_pkg::OP_REF_CHECK) ||
                        (opcode_i == ais_pkg::OP_INPUT_CHECK);

  // Operation kind from opcode
  always_comb begin
    case (opcode_i)
      ais_pkg::OP_REF_CAPTURE: kind_d = ais_pkg::K_REF_CAP;
      ais_pkg::OP_INPUT_CAPTURE: kind_d = ais_pkg::K_IN_CAP;
      ais_pkg::OP_REF_CHECK: kind_d = ais_pkg::K_REF_CHK;
      ais_pkg::OP_INPUT_CHECK: kind_d = ais_pkg::K_IN_CHK;
      default: kind_d = ais_pkg::K_MEASURE;
    endcase
  end

  // Sample evaluation
  assign smp_err = (cv.sample == ais_pkg::SAMPLE_LOW) ||
                   (cv.sample == ais_pkg::SAMPLE_HIGH);
  assign last_smp = (cnt_q[6:0] == rep_q) && (single_q || swap_q);
  assign is_check = (kind_q == ais_pkg::K_REF_CHK) || (kind_q == ais_pkg::K_IN_CHK);
  assign cmp_gt = acc_i[11:0] > cv.sample;
  assign fin = (state_q == ais_pkg::ST_WAIT) && cv.ack &&
               ((kind_q != ais_pkg::K_MEASURE) || smp_err || last_smp);
  assign sum_d = sum_q + {{(ais_pkg::SUM_W-12){1'b0}}, cv.sample};

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ais_pkg::ST_IDLE;
      kind_q <= ais_pkg::K_MEASURE;
      settle_q <= 8'h00;
    end else if (stop) begin
      state_q <= ais_pkg::ST_IDLE;
    end else begin
      case (state_q)
        ais_pkg::ST_IDLE: begin
          if (start && is_sample_op) begin
            kind_q <= kind_d;
            settle_q <= ctrl_settle_q;
            state_q <= is_meas ? ais_pkg::ST_SETTLE : ais_pkg::ST_REQ;
          end
        end
        ais_pkg::ST_SETTLE: begin
          // Measure waits the programmed count plus one cycles after supply on
          if (settle_q == 8'h00) begin
            state_q <= ais_pkg::ST_REQ;
          end else begin
            settle_q <= settle_q - 8'h01;
          end
        end
        ais_pkg::ST_REQ: state_q <= ais_pkg::ST_WAIT;
        ais_pkg::ST_WAIT: begin
          if (fin) begin
            state_q <= ais_pkg::ST_IDLE;
          end else if (cv.ack) begin
            state_q <= ais_pkg::ST_REQ;
          end
        end
        default: state_q <= ais_pkg::ST_IDLE;
      endcase
    end
  end

  // Repeat count, phase and running total
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rep_q <= 7'h00;
      single_q <= 1'b1;
      swap_q <= 1'b0;
      cnt_q <= 8'h00;
      sum_q <= '0;
    end else if (start && is_sample_op) begin
      rep_q <= is_meas ? operand_i[6:0] : 7'h00;
      single_q <= is_meas ? operand_i[7] : 1'b1;
      swap_q <= 1'b0;
      cnt_q <= 8'h00;
      sum_q <= '0;
    end else if ((state_q == ais_pkg::ST_WAIT) && cv.ack && !fin) begin
      sum_q <= sum_d;
      if (cnt_q[6:0] == rep_q) begin
        swap_q <= 1'b1; // second half with swapped inputs
        cnt_q <= 8'h00;
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign cv.req = (state_q == ais_pkg::ST_REQ);
  assign cv.swap = swap_q;

  ////////////////////////////////////////////////////////////////////////
  // Converter supply
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      supply_q <= 1'b0;
    end else if (stop) begin
      supply_q <= 1'b0;
    end else if (start && (opcode_i == ais_pkg::OP_SUPPLY_ON)) begin
      supply_q <= 1'b1;
    end else if (start && (opcode_i == ais_pkg::OP_SUPPLY_OFF)) begin
      supply_q <= 1'b0;
    end else if (start && is_meas) begin
      supply_q <= 1'b1;
    end else if (fin && (kind_q == ais_pkg::K_MEASURE)) begin
      supply_q <= 1'b0;
    end
  end

  // Reference select and input routing
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_sel_q <= 1'b0;
      sel_q <= 2'h0;
    end else begin
      if (start && is_sample_op) begin
        ref_sel_q <= (kind_d == ais_pkg::K_REF_CAP) ||
                     (kind_d == ais_pkg::K_REF_CHK);
      end
      if (start && is_meas) begin
        sel_q <= opcode_i[1:0];
      end else if (state_q == ais_pkg::ST_IDLE) begin
        sel_q <= {input_select_high_i, input_select_low_i};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; supply opcodes leave them alone
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_q <= 1'b0;
      zero_q <= 1'b0;
      neg_q <= 1'b0;
    end else if (fin) begin
      if (is_check) begin
        pos_q <= cmp_gt;
        zero_q <= 1'b0;
        neg_q <= !cmp_gt;
      end else if (smp_err) begin
        pos_q <= 1'b0;
        zero_q <= (cv.sample == ais_pkg::SAMPLE_LOW);
        neg_q <= 1'b1;
      end else begin
        pos_q <= 1'b1;
        zero_q <= 1'b0;
        neg_q <= 1'b0;
      end
    end
  end

  // Accumulator write-back; checks leave it untouched
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_wr_q <= 1'b0;
      acc_data_q <= 32'h0;
      last_sample_q <= 12'h000;
    end else begin
      acc_wr_q <= fin && !is_check;
      if (cv.ack) begin
        last_sample_q <= cv.sample;
      end
      if (fin && (kind_q == ais_pkg::K_MEASURE)) begin
        // On error the partial total is kept, not the bad sample
        acc_data_q <= {{(32-ais_pkg::SUM_W){1'b0}}, smp_err ? sum_q : sum_d};
      end else if (fin && !is_check) begin
        acc_data_q <= {20'h00000, cv.sample};
      end
    end
  end

  // Busy and completion pulse
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= fin || (start && ((opcode_i == ais_pkg::OP_SUPPLY_ON) ||
                (opcode_i == ais_pkg::OP_SUPPLY_OFF)));
      if (stop || fin) begin
        busy_q <= 1'b0;
      end else if (start && is_sample_op) begin
        busy_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_settle_q <= ais_pkg::CTRL_SETTLE_RESET;
    end else if (reg_wr_i && (reg_addr_i == ais_pkg::REG_CTRL)) begin
      ctrl_settle_q <= reg_wdata_i[7:0];
    end
  end

  // Read data valid only the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        ais_pkg::REG_CTRL: rdata_q <= {24'h000000, ctrl_settle_q};
        ais_pkg::REG_STATUS: rdata_q <= {24'h000000, sel_q, busy_q, supply_q,
                                         ref_sel_q, pos_q, zero_q, neg_q};
        ais_pkg::REG_SAMPLE: rdata_q <= {20'h00000, last_sample_q};
        default: rdata_q <= 32'h0;
      endcase
    end else begin
      rdata_q <= 32'h0;
    end
  end

  ais_conv_port u_port (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .cv(cv.port),
    .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i),
    .conv_start_o(conv_start_o),
    .conv_swap_o(conv_swap_o)
  );

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign pos_flag_o = pos_q;
  assign zero_flag_o = zero_q;
  assign negative_flag_o = neg_q;
  assign acc_wr_o = acc_wr_q;
  assign acc_data_o = acc_data_q;
  assign converter_supply_o = supply_q;
  assign reference_select_line_o = ref_sel_q;
  assign input_sel_o = sel_q;
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_sup_on;
    start && (opcode_i == ais_pkg::OP_SUPPLY_ON) |=> converter_supply_o && done_o &&
      $stable({pos_flag_o, zero_flag_o, negative_flag_o});
  endproperty
  a_sup_on: assert property (p_sup_on) else $error("supply on failed");

  property p_sup_off;
    start && (opcode_i == ais_pkg::OP_SUPPLY_OFF) |=> !converter_supply_o &&
      $stable({pos_flag_o, zero_flag_o, negative_flag_o});
  endproperty
  a_sup_off: assert property (p_sup_off) else $error("supply off failed");

  property p_stop;
    stop |=> !converter_supply_o && (state_q == ais_pkg::ST_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("stop left supply on");

  property p_meas_start;
    start && is_meas |=> converter_supply_o && !reference_select_line_o &&
      (input_sel_o == $past(opcode_i[1:0]));
  endproperty
  a_meas_start: assert property (p_meas_start) else $error("measure setup wrong");

  property p_meas_end;
    fin && (kind_q == ais_pkg::K_MEASURE) |=> !converter_supply_o && acc_wr_o && done_o;
  endproperty
  a_meas_end: assert property (p_meas_end) else $error("measure end wrong");

  property p_err;
    fin && !is_check && smp_err |=> negative_flag_o && !pos_flag_o &&
      (zero_flag_o == ($past(cv.sample) == ais_pkg::SAMPLE_LOW));
  endproperty
  a_err: assert property (p_err) else $error("error flags wrong");

  property p_check;
    fin && is_check |=> !zero_flag_o && (pos_flag_o != negative_flag_o) && !acc_wr_o;
  endproperty
  a_check: assert property (p_check) else $error("compare flags wrong");

  property p_ref;
    start && ((opcode_i == ais_pkg::OP_REF_CAPTURE) ||
      (opcode_i == ais_pkg::OP_REF_CHECK)) |=> reference_select_line_o ##1 conv_start_o;
  endproperty
  a_ref: assert property (p_ref) else $error("reference not selected");

endmodule

/* File: tb/ais_front_end_model.sv */
// Behavioural analog comparator front end for the sequencer bench.
// Assumes one start pulse per conversion, sampled on the rising clock edge.
`timescale 1ns/1ps
module ais_front_end_model (
  input wire logic ref_clk_i,
  input wire logic conv_start_i,
  input wire logic conv_swap_i,
  input wire logic [11:0] norm_i,
  input wire logic [11:0] swap_i,
  input wire logic [3:0] delay_i,
  output logic conv_done_o,
  output logic [11:0] conv_data_o
);
  logic swq[$];
  logic s;

  ////////////////////////////////////////////////////////////////////////
  // Starts are queued so one arriving during a done pulse is not lost
  always @(posedge ref_clk_i) begin
    if (conv_start_i === 1'b1)
      swq.push_back(conv_swap_i);
  end

  // One conversion at a time; released data flips so stale values never match
  initial begin
    conv_done_o = 1'b0;
    conv_data_o = 12'h000;
    forever begin
      @(posedge ref_clk_i);
      if (swq.size() != 0) begin
        s = swq.pop_front();
        repeat (delay_i) @(posedge ref_clk_i);
        conv_data_o <= s ? swap_i : norm_i;
        conv_done_o <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o;
        repeat (4) @(posedge ref_clk_i);
      end
    end
  end
endmodule

/* File: tb/ais_adc_sequencer_test.sv */
// Self-checking bench for the converter instruction sequencer.
// Assumes the design package and the front-end model are compiled first.
`timescale 1ns/1ps
module ais_adc_sequencer_test;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] opd;
    logic [11:0] acc;
    logic [11:0] nv;
    logic [11:0] sv;
    logic [1:0] sel;
    logic [2:0] flg;
    logic wr;
    logic [19:0] dat;
    logic [1:0] sup;
    logic rf;
    logic [7:0] ns;
    logic [7:0] nw;
  } ais_row_t;

  logic ref_clk_i = 1'b0;
  logic resetn_i, instr_valid_i, init_i, halt_i, power_off_i;
  logic input_select_low_i, input_select_high_i, reg_wr_i, reg_rd_i;
  logic [7:0] opcode_i, operand_i;
  logic [31:0] acc_i, reg_wdata_i, reg_rdata_o, acc_data_o, rd;
  logic [3:0] reg_addr_i, fe_delay;
  logic busy_o, done_o, pos_flag_o, zero_flag_o, negative_flag_o, acc_wr_o;
  logic converter_supply_o, reference_select_line_o, conv_start_o, conv_swap_o;
  logic conv_done_i;
  logic [1:0] input_sel_o, exp_sel;
  logic [11:0] conv_data_i, norm_val, swap_val;
  logic exp_ref, sel_chk, is_meas;
  int bad_count, checked, waited, n_start, n_swap;
  ais_row_t r;
  // Ordinary cases: opcode, operand, acc, samples, pins, flags, write, total,
  // supply check and level, reference select, starts, swapped starts
  ais_row_t rows [18] = '{
    '{8'h07, 8'h00, 12'h0, 12'h0, 12'h0, 2'h0, 3'h0, 1'h0, 20'h0, 2'h3, 1'h0, 8'h0, 8'h0},
    '{8'h17, 8'h00, 12'h0, 12'h0, 12'h0, 2'h0, 3'h0, 1'h0, 20'h0, 2'h2, 1'h0, 8'h0, 8'h0},
    '{8'hac, 8'h00, 12'h0, 12'h100, 12'h0f0, 2'h3, 3'h4, 1'h1, 20'h1f0, 2'h2, 1'h0, 8'h2, 8'h1},
    '{8'had, 8'h03, 12'h0, 12'h200, 12'h100, 2'h0, 3'h4, 1'h1, 20'hc00, 2'h2, 1'h0, 8'h8, 8'h4},
    '{8'hae, 8'h82, 12'h0, 12'h123, 12'h0, 2'h1, 3'h4, 1'h1, 20'h369, 2'h2, 1'h0, 8'h3, 8'h0},
    '{8'haf, 8'hff, 12'h0, 12'h010, 12'h0, 2'h0, 3'h4, 1'h1, 20'h800, 2'h2, 1'h0, 8'h80, 8'h0},
    '{8'hac, 8'h05, 12'h0, 12'h000, 12'h0f0, 2'h2, 3'h3, 1'h1, 20'h0, 2'h2, 1'h0, 8'h1, 8'h0},
    '{8'had, 8'h85, 12'h0, 12'hfff, 12'h0, 2'h1, 3'h1, 1'h1, 20'h0, 2'h2, 1'h0, 8'h1, 8'h0},
    '{8'h07, 8'h00, 12'h0, 12'h0, 12'h0, 2'h0, 3'h1, 1'h0, 20'h0, 2'h3, 1'h0, 8'h0, 8'h0},
    '{8'he8, 8'h00, 12'h0, 12'h5a5, 12'h0, 2'h0, 3'h4, 1'h1, 20'h5a5, 2'h0, 1'h1, 8'h1, 8'h0},
    '{8'he8, 8'h00, 12'h0, 12'hfff, 12'h0, 2'h0, 3'h1, 1'h1, 20'hfff, 2'h0, 1'h1, 8'h1, 8'h0},
    '{8'he9, 8'h00, 12'h0, 12'h3c3, 12'h0, 2'h3, 3'h4, 1'h1, 20'h3c3, 2'h0, 1'h0, 8'h1, 8'h0},
    '{8'he9, 8'h00, 12'h0, 12'h000, 12'h0, 2'h2, 3'h3, 1'h1, 20'h0, 2'h0, 1'h0, 8'h1, 8'h0},
    '{8'hea, 8'h00, 12'h800, 12'h400, 12'h0, 2'h0, 3'h4, 1'h0, 20'h0, 2'h0, 1'h1, 8'h1, 8'h0},
    '{8'hea, 8'h00, 12'h100, 12'h400, 12'h0, 2'h0, 3'h1, 1'h0, 20'h0, 2'h0, 1'h1, 8'h1, 8'h0},
    '{8'heb, 8'h00, 12'h700, 12'h300, 12'h0, 2'h1, 3'h4, 1'h0, 20'h0, 2'h0, 1'h0, 8'h1, 8'h0},
    '{8'heb, 8'h00, 12'h200, 12'h300, 12'h0, 2'h0, 3'h1, 1'h0, 20'h0, 2'h0, 1'h0, 8'h1, 8'h0},
    '{8'h17, 8'h00, 12'h0, 12'h0, 12'h0, 2'h0, 3'h1, 1'h0, 20'h0, 2'h2, 1'h0, 8'h0, 8'h0}
  };

  ////////////////////////////////////////////////////////////////////////
  // Clock, design and front end
  always #4 ref_clk_i = ~ref_clk_i;

  ais_adc_sequencer i_dut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
    .opcode_i(opcode_i), .operand_i(operand_i), .acc_i(acc_i), .init_i(init_i),
    .halt_i(halt_i), .power_off_i(power_off_i), .input_select_low_i(input_select_low_i),
    .input_select_high_i(input_select_high_i), .busy_o(busy_o), .done_o(done_o),
    .pos_flag_o(pos_flag_o), .zero_flag_o(zero_flag_o), .negative_flag_o(negative_flag_o),
    .acc_wr_o(acc_wr_o), .acc_data_o(acc_data_o), .converter_supply_o(converter_supply_o),
    .reference_select_line_o(reference_select_line_o), .input_sel_o(input_sel_o),
    .conv_start_o(conv_start_o), .conv_swap_o(conv_swap_o), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o)
  );

  ais_front_end_model i_fe (
    .ref_clk_i(ref_clk_i), .conv_start_i(conv_start_o), .conv_swap_i(conv_swap_o),
    .norm_i(norm_val), .swap_i(swap_val), .delay_i(fe_delay),
    .conv_done_o(conv_done_i), .conv_data_o(conv_data_i)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic send_op(input logic [7:0] op, input logic [7:0] opd);
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b1;
    opcode_i <= op;
    operand_i <= opd;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
  endtask

  // Bounded wait so a lost completion shows as a mismatch, not a hang
  task automatic wait_done(input int lim);
    waited = 0;
    @(negedge ref_clk_i);
    while (done_o !== 1'b1 && waited < lim) begin
      @(negedge ref_clk_i);
      waited++;
    end
  endtask

  task automatic expect_op(input logic [7:0] op, input logic [1:0] sel, input logic rf);
    is_meas = op[7:2] == ais_pkg::OP_MEASURE_HI;
    sel_chk = is_meas || op == ais_pkg::OP_INPUT_CAPTURE || op == ais_pkg::OP_INPUT_CHECK;
    exp_sel = is_meas ? op[1:0] : sel;
    exp_ref = rf;
    n_start = 0;
    n_swap = 0;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    rd = reg_rdata_o;
  endtask

  // Front-end requests: reference select must be settled at each start, input routing for measures and input ops, supply for measures
  always @(posedge ref_clk_i) begin
    if (conv_start_o === 1'b1) begin
      n_start++;
      if (conv_swap_o === 1'b1)
        n_swap++;
      check({31'h0, reference_select_line_o}, {31'h0, exp_ref});
      if (sel_chk)
        check({30'h0, input_sel_o}, {30'h0, exp_sel});
      if (is_meas)
        check({31'h0, converter_supply_o}, 32'h1);
    end
  end

  // Hang guard, well above the longest expected run
  initial begin
    repeat (30000) @(posedge ref_clk_i);
    bad_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {resetn_i, instr_valid_i, init_i, halt_i, power_off_i, reg_wr_i, reg_rd_i} = 7'h00;
    {input_select_low_i, input_select_high_i} = 2'h0;
    {opcode_i, operand_i, acc_i, reg_wdata_i, reg_addr_i} = 84'h0;
    {norm_val, swap_val, fe_delay} = 28'h0;
    expect_op(8'h00, 2'h0, 1'b0);
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(negedge ref_clk_i);
    check({23'h0, busy_o, done_o, pos_flag_o, zero_flag_o, negative_flag_o, acc_wr_o,
           converter_supply_o, reference_select_line_o, conv_start_o}, 32'h0);
    reg_read(ais_pkg::REG_CTRL);
    check(rd, {24'h0, ais_pkg::CTRL_SETTLE_RESET});
    reg_write(ais_pkg::REG_CTRL, 32'h2);
    reg_write(4'hc, 32'hff);
    reg_read(4'hc);
    check(rd, 32'h0);
    reg_read(ais_pkg::REG_CTRL);
    check(rd, 32'h2);
    $display("reset and register test done");
    // Table of ordinary cases, front end alternating prompt and slow
    for (int i = 0; i < 18; i++) begin
      r = rows[i];
      @(posedge ref_clk_i);
      {input_select_high_i, input_select_low_i} <= r.sel;
      {norm_val, swap_val} <= {r.nv, r.sv};
      acc_i <= {20'h0, r.acc};
      fe_delay <= i[0] ? 4'hc : 4'h1;
      expect_op(r.op, r.sel, r.rf);
      send_op(r.op, r.opd);
      wait_done(6000);
      check({31'h0, done_o}, 32'h1);
      if (r.ns == 8'h0)
        check(waited, 32'h0);
      check({29'h0, pos_flag_o, zero_flag_o, negative_flag_o}, {29'h0, r.flg});
      check({31'h0, acc_wr_o}, {31'h0, r.wr});
      if (r.wr)
        check(acc_data_o, {12'h0, r.dat});
      if (r.sup[1])
        check({31'h0, converter_supply_o}, {31'h0, r.sup[0]});
      check({31'h0, reference_select_line_o}, {31'h0, r.rf});
      check(n_start, {24'h0, r.ns});
      check(n_swap, {24'h0, r.nw});
      $display("row %0d done", i);
    end
    reg_read(ais_pkg::REG_STATUS);
    check(rd, 32'h1);
    // Request while busy is dropped; unknown opcode gives no completion
    norm_val <= 12'h010;
    expect_op(8'hae, 2'h0, 1'b0);
    send_op(8'hae, 8'h83);
    repeat (3) @(posedge ref_clk_i);
    send_op(8'he8, 8'h00);
    wait_done(3000);
    check(acc_data_o, 32'h40);
    check({31'h0, reference_select_line_o}, 32'h0);
    send_op(8'h55, 8'h00);
    wait_done(40);
    check({31'h0, done_o}, 32'h0);
    reg_read(ais_pkg::REG_SAMPLE);
    check(rd, 32'h10);
    $display("refusal test done");
    // Each stop input aborts a running measure and drops the supply
    for (int k = 0; k < 3; k++) begin
      expect_op(8'haf, 2'h0, 1'b0);
      send_op(8'haf, 8'h7f);
      repeat (30) @(negedge ref_clk_i);
      check({31'h0, converter_supply_o}, 32'h1);
      @(posedge ref_clk_i);
      {init_i, halt_i, power_off_i} <= 3'b100 >> k;
      @(posedge ref_clk_i);
      {init_i, halt_i, power_off_i} <= 3'b000;
      repeat (3) @(negedge ref_clk_i);
      check({30'h0, converter_supply_o, busy_o}, 32'h0);
      repeat (40) @(negedge ref_clk_i);
    end
    $display("stop test done");
    tally_and_finish();
  end
endmodule
